/* File: design/scfg_pkg.sv */
// Purpose: shared constants for the synthesizer configuration block
// Assumes: 40 MHz system clock, serial port and divider pulses asynchronous
// Notes: bit positions of the configuration byte and current tables
package scfg_pkg;
    // ------------------------------------------------------------
    // configuration byte layout
    // ------------------------------------------------------------
    localparam int CFG_W = 8;
    localparam int BIT_INVERT = 7;
    localparam int BIT_DET_SEL = 6;
    localparam int BIT_LOCK_EN = 5;
    localparam int BIT_SLEEP = 4;
    localparam int BIT_LVL_HI = 3;
    localparam int BIT_LVL_LO = 2;
    localparam int BIT_PORT = 1;
    localparam int BIT_OUT_B = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [4:0] XFER_BITS = 5'h08;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    // ------------------------------------------------------------
    // reference mode that parks the reference output low
    // ------------------------------------------------------------
    localparam logic [2:0] REF_MODE_STATIC_LOW = 3'h0;
    // ------------------------------------------------------------
    // pump current in percent of full scale
    // ------------------------------------------------------------
    localparam logic [6:0] FINE_BASE = 7'h46;
    localparam logic [6:0] FINE_STEP = 7'h0a;
    localparam logic [6:0] COARSE_BASE = 7'h19;
    localparam logic [6:0] COARSE_STEP = 7'h19;
    // ------------------------------------------------------------
    // serial-port initialisation hold time of the clock line
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int INIT_HOLD_NS = 100;
    localparam int INIT_HOLD_CYC = (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // standby sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_SLEEP = 2'h1,
        ST_WAKE = 2'h3
    } scfg_state_t;
endpackage : scfg_pkg

/* File: design/scfg_core.sv */
// Purpose: configuration register, detector steering and standby recovery
// Assumes: serial pins and divider pulses are asynchronous to clk_in
// Notes: divider counters live elsewhere; this block gates them and pulses the reference jam load
`timescale 1ns/100ps
`default_nettype none
module scfg_core (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic serial_enable_pin_n_in,
    input wire logic ref_compare_rate_in,
    input wire logic vco_compare_rate_in,
    input wire logic port_mode_in,
    input wire logic [2:0] ref_mode_in,
    output logic single_ended_pump_output_src_out,
    output logic single_ended_pump_output_snk_out,
    output logic single_ended_pump_output_oe_out,
    output logic phase_ref_n_out,
    output logic phase_vco_n_out,
    output logic lock_indicator_out,
    output logic [6:0] pump_current_level_out,
    output logic output_a_out,
    output logic output_b_out,
    output logic output_b_oe_out,
    output logic counters_run_out,
    output logic bias_on_out,
    output logic ref_resistor_on_out,
    output logic reference_input_inhibit_out,
    output logic ref_jam_load_out,
    output logic [scfg_pkg::CFG_W-1:0] detector_config_byte_out
);
    import scfg_pkg::*;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] next_sync1;
    logic [4:0] next_sync2;
    logic [4:0] next_sync3;

    always_comb begin
        next_sync1 = {vco_compare_rate_in, ref_compare_rate_in, serial_enable_pin_n_in,
                      serial_data_in, serial_clk_in};
        next_sync2 = sync1;
        next_sync3 = sync2;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1 <= 5'h04;
            sync2 <= 5'h04;
            sync3 <= 5'h04;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
        end
    end

    logic sclk_rise;
    logic sdata;
    logic en_n;
    logic en_rise;
    logic fr_rise;
    logic fv_rise;

    always_comb begin
        sclk_rise = sync2[0] & ~sync3[0];
        sdata = sync2[1];
        en_n = sync2[2];
        en_rise = sync2[2] & ~sync3[2];
        fr_rise = sync2[3] & ~sync3[3];
        fv_rise = sync2[4] & ~sync3[4];
    end

    // ------------------------------------------------------------
    // serial shifter and configuration register
    // ------------------------------------------------------------
    logic [7:0] shifter;
    logic [4:0] bit_cnt;
    logic [7:0] cfg;
    logic [7:0] next_shifter;
    logic [4:0] next_bit_cnt;
    logic [7:0] next_cfg;

    always_comb begin
        next_shifter = shifter;
        next_bit_cnt = bit_cnt;
        next_cfg = cfg;
        if (!en_n && sclk_rise) begin
            // msb arrives first, so it ends up in bit 7
            next_shifter = {shifter[6:0], sdata};
            if (bit_cnt != CNT_MAX) begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
        end
        if (en_rise) begin
            next_bit_cnt = 5'h00;
            // longer transfers belong to other registers and leave cfg alone
            if (bit_cnt == XFER_BITS) begin
                next_cfg = shifter;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shifter <= 8'h00;
            bit_cnt <= 5'h00;
            cfg <= CFG_RESET;
        end else begin
            shifter <= next_shifter;
            bit_cnt <= next_bit_cnt;
            cfg <= next_cfg;
        end
    end

    // ------------------------------------------------------------
    // standby sequencer
    // ------------------------------------------------------------
    scfg_state_t state;
    scfg_state_t next_state;
    logic jam;
    logic next_jam;

    always_comb begin
        next_state = state;
        next_jam = 1'b0;
        case (state)
            ST_RUN: begin
                if (cfg[BIT_SLEEP]) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!cfg[BIT_SLEEP]) begin
                    next_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (cfg[BIT_SLEEP]) begin
                    next_state = ST_SLEEP;
                end else if (fv_rise) begin
                    next_state = ST_RUN;
                    next_jam = 1'b1;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= ST_RUN;
            jam <= 1'b0;
        end else begin
            state <= next_state;
            jam <= next_jam;
        end
    end

    // ------------------------------------------------------------
    // phase/frequency detector core
    // ------------------------------------------------------------
    logic r_flag;
    logic v_flag;
    logic next_r_flag;
    logic next_v_flag;
    logic det_live;

    always_comb begin
        // the cycle after the jam load still holds the flags clear, so both start fresh
        det_live = (state == ST_RUN) && !jam;
        next_r_flag = r_flag | fr_rise;
        next_v_flag = v_flag | fv_rise;
        // both edges seen: reset together, giving the short coincident pulse
        // a fresh edge landing in the clearing cycle is kept, the set wins
        if (r_flag && v_flag) begin
            next_r_flag = fr_rise;
            next_v_flag = fv_rise;
        end
        // divider pulses are kept out until the first vco pulse after waking
        if (!det_live) begin
            next_r_flag = 1'b0;
            next_v_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_flag <= 1'b0;
            v_flag <= 1'b0;
        end else begin
            r_flag <= next_r_flag;
            v_flag <= next_v_flag;
        end
    end

    // ------------------------------------------------------------
    // pump current table
    // ------------------------------------------------------------
    function automatic logic [6:0] pump_pct(input logic coarse, input logic [1:0] lvl);
        logic [6:0] idx;
        idx = {5'h00, lvl};
        if (coarse) begin
            pump_pct = COARSE_BASE + 7'(idx * COARSE_STEP);
        end else begin
            pump_pct = FINE_BASE + 7'(idx * FINE_STEP);
        end
    endfunction : pump_pct

    // ------------------------------------------------------------
    // output stage, all registered except output_b_out, tied low
    // ------------------------------------------------------------
    logic [12:0] outs;
    logic [12:0] next_outs;
    logic [6:0] pct;
    logic [6:0] next_pct;
    logic asleep;
    logic waking;
    logic inv;
    logic raw_r_n;
    logic raw_v_n;
    logic phr_n;
    logic phv_n;

    always_comb begin
        asleep = (state == ST_SLEEP);
        waking = (state == ST_WAKE);
        inv = cfg[BIT_INVERT];
        raw_r_n = ~r_flag;
        raw_v_n = ~v_flag;
        // pair swaps roles with the invert bit
        phr_n = inv ? raw_v_n : raw_r_n;
        phv_n = inv ? raw_r_n : raw_v_n;
        if (cfg[BIT_DET_SEL] || asleep) begin
            phr_n = 1'b1;
            phv_n = 1'b1;
        end
        next_outs = 13'h0000;
        next_outs[3] = phr_n;
        next_outs[4] = phv_n;
        // vco ahead sinks, reference ahead sources; invert flips it
        next_outs[0] = inv ? v_flag : r_flag;
        next_outs[1] = inv ? r_flag : v_flag;
        next_outs[2] = cfg[BIT_DET_SEL] && !asleep;
        if (asleep) begin
            next_outs[5] = cfg[BIT_LOCK_EN];
        end else if (cfg[BIT_LOCK_EN]) begin
            // gated pair in waking reads high, so no false unlock pulses
            next_outs[5] = (inv ? raw_v_n : raw_r_n) & (inv ? raw_r_n : raw_v_n);
        end else begin
            next_outs[5] = 1'b0;
        end
        // port level ignores sleep; otherwise serial data out chains devices
        next_outs[6] = port_mode_in ? cfg[BIT_PORT] : shifter[7];
        next_outs[7] = ~cfg[BIT_OUT_B];
        next_outs[8] = !asleep;
        next_outs[9] = !asleep;
        next_outs[10] = !(asleep && ref_mode_in == REF_MODE_STATIC_LOW);
        next_outs[11] = asleep && ref_mode_in == REF_MODE_STATIC_LOW;
        next_outs[12] = waking && fv_rise;
        next_pct = pump_pct(cfg[BIT_PORT] && !port_mode_in,
                            {cfg[BIT_LVL_HI], cfg[BIT_LVL_LO]});
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // pair high, open drain pulling, counters, bias and resistor on
            outs <= 13'h0798;
            pct <= FINE_BASE;
        end else begin
            outs <= next_outs;
            pct <= next_pct;
        end
    end

    always_comb begin
        single_ended_pump_output_src_out = outs[0];
        single_ended_pump_output_snk_out = outs[1];
        single_ended_pump_output_oe_out = outs[2];
        phase_ref_n_out = outs[3];
        phase_vco_n_out = outs[4];
        lock_indicator_out = outs[5];
        output_a_out = outs[6];
        output_b_out = 1'b0;
        output_b_oe_out = outs[7];
        counters_run_out = outs[8];
        bias_on_out = outs[9];
        ref_resistor_on_out = outs[10];
        reference_input_inhibit_out = outs[11];
        ref_jam_load_out = outs[12];
        pump_current_level_out = pct;
        detector_config_byte_out = cfg;
    end
endmodule : scfg_core
`default_nettype wire

/* File: verification/scfg_props.sv */
// Purpose: port-level checks of the configuration block
// Assumes: outputs derived from the byte follow it by one clock
// Notes: standby outputs trail the byte by two clocks (state, then outputs)
`timescale 1ns/100ps
`default_nettype none
module scfg_props
    import scfg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic serial_enable_pin_n_in,
    input wire logic port_mode_in,
    input wire logic [2:0] ref_mode_in,
    input wire logic single_ended_pump_output_oe_out,
    input wire logic phase_ref_n_out,
    input wire logic phase_vco_n_out,
    input wire logic lock_indicator_out,
    input wire logic [6:0] pump_current_level_out,
    input wire logic output_a_out,
    input wire logic output_b_oe_out,
    input wire logic counters_run_out,
    input wire logic bias_on_out,
    input wire logic reference_input_inhibit_out,
    input wire logic ref_jam_load_out,
    input wire logic [CFG_W-1:0] detector_config_byte_out
);
    logic [7:0] c;
    logic [6:0] lv;
    logic [6:0] pct;
    assign c = detector_config_byte_out;
    assign lv = {5'h00, c[BIT_LVL_HI:BIT_LVL_LO]};
    // port mode keeps the fine table whatever bit 1 holds
    assign pct = (port_mode_in || !c[BIT_PORT]) ? FINE_BASE + FINE_STEP * lv
                                                : COARSE_BASE + COARSE_STEP * lv;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_byte_frame_end: assert property (
        !$stable(c) && !$past(rst_in) |->
        serial_enable_pin_n_in && $past(serial_enable_pin_n_in, 2)) else $error("byte off frame");
    a_pair_parked: assert property (
        $past(c[BIT_DET_SEL]) |->
        phase_ref_n_out && phase_vco_n_out) else $error("pair not parked");
    a_sleep_outputs: assert property (
        $past(c[BIT_SLEEP], 2) && $past(c[BIT_SLEEP]) |->
        !single_ended_pump_output_oe_out && phase_ref_n_out && phase_vco_n_out
        && !counters_run_out && !bias_on_out) else $error("sleep outputs wrong");
    a_lock_forced_low: assert property (
        !$past(c[BIT_LOCK_EN]) |-> !lock_indicator_out)
        else $error("lock not low");
    a_sleep_lock_high: assert property (
        $past(c[BIT_SLEEP], 2) && $past(c[BIT_SLEEP])
        && $past(c[BIT_LOCK_EN]) |-> lock_indicator_out) else $error("sleep lock not high");
    a_level_table: assert property (
        !$past(rst_in) |->
        pump_current_level_out == $past(pct)) else $error("pump level wrong");
    a_port_level: assert property (
        $past(port_mode_in) |->
        output_a_out == $past(c[BIT_PORT])) else $error("port level wrong");
    a_out_b_drive: assert property (
        output_b_oe_out == !$past(c[BIT_OUT_B]))
        else $error("open drain wrong");
    a_wake_running: assert property (
        !$past(c[BIT_SLEEP], 2) && !$past(c[BIT_SLEEP]) |->
        counters_run_out && bias_on_out) else $error("counters not running");
    a_inhibit_cause: assert property (
        reference_input_inhibit_out |->
        $past(c[BIT_SLEEP], 2) && $past(ref_mode_in) == REF_MODE_STATIC_LOW)
        else $error("inhibit without cause");
    a_jam_single: assert property (
        ref_jam_load_out |=> !ref_jam_load_out)
        else $error("jam pulse too long");
    c_sleep_inhibit: cover property (reference_input_inhibit_out);
    c_jam_load: cover property (ref_jam_load_out);
    c_coarse_low: cover property (pump_current_level_out == COARSE_BASE);
endmodule : scfg_props
bind scfg_core scfg_props u_scfg_props (.*);
`default_nettype wire

/* File: verification/scfg_host.sv */
// Purpose: host model driving the serial clock, data and enable pins
// Assumes: hp is the half period in ns, a multiple of the 25 ns clock
// Notes: clock idles low between frames
`timescale 1ns/100ps
`default_nettype none
module scfg_host (
    input wire logic clk_in,
    output logic sclk_out,
    output logic sdata_out,
    output logic en_n_out
);
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        en_n_out = 1'b1;
    end
    // every pin moves just after a clock edge, hp / 25 edges apart
    task automatic send(input logic [15:0] bits, input int n, input logic park_hi, input int hp);
        en_n_out <= 1'b0;
        repeat (hp / 25) @(posedge clk_in);
        for (int i = n - 1; i >= 0; i--) begin
            sdata_out <= bits[i];
            repeat (hp / 25) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i > 0 || !park_hi) begin
                repeat (hp / 25) @(posedge clk_in);
                sclk_out <= 1'b0;
            end
        end
        repeat (hp / 25) @(posedge clk_in);
        en_n_out <= 1'b1;
        // init groups hold the clock high past the enable edge
        repeat (hp / 25) @(posedge clk_in);
        sclk_out <= 1'b0;
        // released data must not look like the last bit
        sdata_out <= ~sdata_out;
    endtask : send
endmodule : scfg_host
`default_nettype wire

/* File: verification/scfg_core_tb_top.sv */
// Purpose: self-checking bench for the configuration block
// Assumes: host model drives the serial pins, bench drives divider pulses
// Notes: expectations come from an integer model of the byte
`timescale 1ns/100ps
`default_nettype none
module scfg_core_tb_top;
    import scfg_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ref_compare_rate_in = 1'b0;
    logic vco_compare_rate_in = 1'b0;
    logic port_mode_in = 1'b0;
    logic [2:0] ref_mode_in = 3'h2;
    wire logic sck, sdi, sen_n, src, snk, poe, rfn, vcn, lock, oa, oboe, run, bias, res, inh, jam;
    wire logic [6:0] pct;
    wire logic [7:0] cfg;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int exp_cfg = 0;
    int lens[5] = '{7, 9, 5, 5, 5};
    logic [7:0] b;
    scfg_host u_scfg_host (.clk_in(clk_in), .sclk_out(sck), .sdata_out(sdi), .en_n_out(sen_n));
    scfg_core u_scfg_core (.clk_in, .rst_in, .serial_clk_in(sck), .serial_data_in(sdi),
        .serial_enable_pin_n_in(sen_n), .ref_compare_rate_in, .vco_compare_rate_in,
        .port_mode_in, .ref_mode_in, .single_ended_pump_output_src_out(src),
        .single_ended_pump_output_snk_out(snk), .single_ended_pump_output_oe_out(poe),
        .phase_ref_n_out(rfn), .phase_vco_n_out(vcn), .lock_indicator_out(lock),
        .pump_current_level_out(pct), .output_a_out(oa), .output_b_out(),
        .output_b_oe_out(oboe), .counters_run_out(run), .bias_on_out(bias),
        .ref_resistor_on_out(res), .reference_input_inhibit_out(inh),
        .ref_jam_load_out(jam), .detector_config_byte_out(cfg));
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] v);
        // 100 ns half period gives the 200 ns serial clock
        u_scfg_host.send({8'h00, v}, 8, 1'b0, 100);
        exp_cfg = v;
        repeat (8) @(posedge clk_in);
    endtask : wr
    task automatic pulse(input logic r, input logic v);
        ref_compare_rate_in <= r;
        vco_compare_rate_in <= v;
        repeat (6) @(posedge clk_in);
    endtask : pulse
    task automatic check_run();
        int lv;
        int ep;
        lv = (exp_cfg >> 2) & 3;
        ep = (port_mode_in || !exp_cfg[1]) ? 70 + 10 * lv : 25 + 25 * lv;
        chk(cfg, 16'(exp_cfg));
        chk(pct, 16'(ep));
        chk({poe, src, snk, rfn, vcn}, {exp_cfg[6], 4'h3});
        chk({lock, oboe}, {exp_cfg[5], !exp_cfg[0]});
        // outside port mode the pin carries data out: the first bit shifted in
        if (port_mode_in) chk(oa, exp_cfg[1]);
        else chk(oa, exp_cfg[7]);
    endtask : check_run
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        void'($urandom(32'h5320));
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        // every level code under both table selects and both port modes
        for (int i = 0; i < 16; i++) begin
            b = (8'($urandom) & 8'he1) | {4'h0, 3'(i), 1'b0};
            port_mode_in <= i[3];
            wr(b);
            check_run();
            pulse(1'b1, 1'b0);
            if (b[6]) chk({src, snk}, {!b[7], b[7]});
            else chk({rfn, vcn, lock}, {b[7], !b[7], 1'b0});
            pulse(1'b1, 1'b1);
            pulse(1'b0, 1'b0);
            chk({src, snk, rfn, vcn}, 4'h3);
        end
        foreach (lens[k]) begin
            u_scfg_host.send(16'h01a5, lens[k], lens[k] == 5, 100);
            repeat (8) @(posedge clk_in);
            chk(cfg, 16'(exp_cfg));
        end
        port_mode_in <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            ref_mode_in <= k ? 3'h2 : REF_MODE_STATIC_LOW;
            b = k ? 8'h13 : 8'h33;
            wr(b);
            pulse(1'b1, 1'b0);
            chk({cfg, poe, rfn, vcn, run, bias}, {b, 5'h0c});
            chk({lock, oa}, {b[5], 1'b1});
            chk({oboe, inh, res}, {1'b0, !k[0], k[0]});
            pulse(1'b0, 1'b0);
        end
        wr(8'h23);
        pulse(1'b1, 1'b0);
        chk({run, bias, res, inh, rfn, vcn, lock, jam}, 8'hee);
        vco_compare_rate_in <= 1'b1;
        for (int t = 0; t < 12 && jam !== 1'b1; t++) @(negedge clk_in);
        chk(jam, 1'b1);
        @(posedge clk_in);
        pulse(1'b0, 1'b0);
        pulse(1'b1, 1'b0);
        chk({rfn, vcn, lock}, 3'h2);
        pulse(1'b1, 1'b1);
        pulse(1'b0, 1'b0);
        // leave port mode so the power-up data-out function is visible on the pin
        rst_in <= 1'b1;
        port_mode_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        exp_cfg = 0;
        check_run();
        chk(oa, 1'b0);
        tally_and_finish();
    end
endmodule : scfg_core_tb_top
`default_nettype wire
